// file: hw/antg_pkg.sv
package antg_pkg;

    localparam int TIME_W    = 5;
    localparam int ADDR_W    = 24;
    localparam int DATA_W    = 16;
    localparam int BE_W      = 2;
    localparam int MAX_BEATS = 4;
    localparam int BEAT_W    = 2;
    localparam int CNT_W     = 12;
    localparam int SYNC_LAT  = 2;
    localparam int DIV_W     = 2;

    localparam logic [DIV_W-1:0] DIV_BY_1 = 2'h0;
    localparam logic [DIV_W-1:0] DIV_BY_2 = 2'h1;
    localparam logic [DIV_W-1:0] DIV_BY_3 = 2'h2;
    localparam logic [DIV_W-1:0] DIV_BY_4 = 2'h3;

    localparam logic [BE_W-1:0]  BE_NONE  = 2'h3;
    localparam logic [CNT_W-1:0] CNT_ONE  = 12'h001;

    typedef struct packed {
        logic [DIV_W-1:0]  clk_divide_ratio;
        logic              timing_scale_double;
        logic [TIME_W-1:0] select_assert_time;
        logic [TIME_W-1:0] select_read_release_time;
        logic [TIME_W-1:0] select_write_release_time;
        logic [TIME_W-1:0] addr_valid_assert_time;
        logic [TIME_W-1:0] addr_valid_read_release_time;
        logic [TIME_W-1:0] addr_valid_write_release_time;
        logic [TIME_W-1:0] read_strobe_assert_time;
        logic [TIME_W-1:0] read_strobe_release_time;
        logic [TIME_W-1:0] write_strobe_assert_time;
        logic [TIME_W-1:0] write_strobe_release_time;
        logic [TIME_W-1:0] data_sample_time;
        logic [TIME_W-1:0] page_step_time;
        logic [TIME_W-1:0] read_cycle_length;
        logic [TIME_W-1:0] write_cycle_length;
        logic [TIME_W-1:0] inter_access_gap;
        logic [TIME_W-1:0] bus_clock_start_time;
        logic              select_half_cycle_delay;
        logic              addr_valid_half_cycle_delay;
        logic              read_strobe_half_cycle_delay;
        logic              write_strobe_half_cycle_delay;
    } antg_cfg_t;

    typedef struct packed {
        logic                                write;
        logic [BEAT_W-1:0]                   beats_minus_1;
        logic [ADDR_W-1:0]                   addr;
        logic [BE_W-1:0]                     be_n;
        logic [MAX_BEATS-1:0][DATA_W-1:0]    wdata;
    } antg_req_t;

    typedef enum logic [2:0] {
        ST_IDLE   = 3'h1,
        ST_ACCESS = 3'h2,
        ST_GAP    = 3'h4
    } antg_state_t;

endpackage

// file: hw/antg_strobe.sv
module antg_strobe
    import antg_pkg::*;
(
    input  wire logic             mclk_in,
    input  wire logic             rst_n_in,
    input  wire logic             active_in,
    input  wire logic [CNT_W-1:0] cnt_in,
    input  wire logic [CNT_W-1:0] assert_at_in,
    input  wire logic [CNT_W-1:0] release_at_in,
    input  wire logic             half_in,
    output logic                  strobe_n_out
);

    logic lvl_nxt;
    logic lvl_r;

    assign lvl_nxt = active_in && (cnt_in >= assert_at_in) && (cnt_in < release_at_in);

    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            lvl_r <= 1'b0;
        end else begin
            lvl_r <= lvl_nxt;
        end
    end

    // Falling-edge launch: the half-cycle bit picks last cycle's level
    always_ff @(negedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            strobe_n_out <= 1'b1;
        end else begin
            strobe_n_out <= ~(half_in ? lvl_r : lvl_nxt);
        end
    end

    AST_STROBE_QUIET: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
        (!active_in ##1 !active_in) |-> strobe_n_out) else $error("strobe active outside access"); // R10

endmodule // antg_strobe

// file: hw/antg_bus_clock.sv
module antg_bus_clock
    import antg_pkg::*;
(
    input  wire logic             mclk_in,
    input  wire logic             rst_n_in,
    input  wire logic             run_in,
    input  wire logic [DIV_W-1:0] ratio_in,
    output logic                  bus_clk_out
);

    logic [DIV_W-1:0] phase_r;
    logic [DIV_W-1:0] phase_nxt;
    logic [DIV_W:0]   high_len;

    // Divider restarts at the programmed start so edge alignment is repeatable
    assign phase_nxt = (!run_in || phase_r >= ratio_in) ? '0 : phase_r + DIV_W'(1);
    assign high_len  = ({1'b0, ratio_in} + (DIV_W + 1)'(2)) >> 1;

    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            phase_r <= '0;
        end else begin
            phase_r <= phase_nxt;
        end
    end

    // R5: divided clock, functional clock never driven out
    // R21: only this divider flop reaches the pin
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            bus_clk_out <= 1'b0;
        end else begin
            bus_clk_out <= run_in && ({1'b0, phase_nxt} < high_len);
        end
    end

    AST_PHASE_BOUND: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
        run_in |=> (phase_r <= $past(ratio_in))) else $error("bus clock phase past divide ratio"); // R5

endmodule // antg_bus_clock

// file: hw/antg_timing_gen.sv
// Overview of operation
// R1: Ratio 0/1 write release alignment rule
// R2: Ratio 2 write release adds mod-3 cycles
// R3: Ratio 3 write release adds mod-4 cycles
// R4: Address-valid low for release minus assert
// R5: Bus clock divided from functional clock
// R6: Single read samples at sample time
// R7: Page mode first word at sample time
// R8: Later page words every page step
// R9: Byte enables held for cycle length
// R10: Chip select low assert to release
// R11: Address-valid release relative to select
// R12: Read strobe release relative to select
// R13: Address and data valid before select
// R14: Address-valid assert relative to select
// R15: Read strobe assert relative to select
// R16: Address invalid for gap between accesses
// R17: Burst read strobe release adds page steps
// R18: Later burst addresses last one page step
// R19: Write strobe assert relative to select
// R20: Write strobe release relative to select
// R21: Functional clock stays internal
// R22: Internal bus direction flag kept
// R23: Counter restarts at each access
// R24: Memory holds data until strobe release
module antg_timing_gen
    import antg_pkg::*;
(
    input  wire logic              mclk_in,
    input  wire logic              rst_n_in,
    input  wire logic              start_in,
    input  wire antg_req_t         req_in,
    input  wire antg_cfg_t         cfg_in,
    input  wire logic [DATA_W-1:0] ad_in,
    output logic                   ready_out,
    output logic                   cs_n_out,
    output logic                   adv_n_out,
    output logic                   oe_n_out,
    output logic                   we_n_out,
    output logic                   bus_clk_out,
    output logic [ADDR_W-1:0]      addr_out,
    output logic [BE_W-1:0]        be_n_out,
    output logic [DATA_W-1:0]      ad_out,
    output logic                   ad_oe_out,
    output logic [DATA_W-1:0]      rdata_out,
    output logic                   rdata_valid_out
);

    function automatic logic [CNT_W-1:0] scale(input logic [CNT_W-1:0] t, input logic dbl);
        scale = dbl ? {t[CNT_W-2:0], 1'b0} : t;
    endfunction

    function automatic logic [CNT_W-1:0] with_burst(input logic [TIME_W-1:0] t,
                                                    input logic [BEAT_W-1:0] nm1,
                                                    input logic [TIME_W-1:0] step);
        with_burst = CNT_W'(t) + CNT_W'(CNT_W'(nm1) * CNT_W'(step));
    endfunction

    function automatic logic [1:0] align_extra(input logic [DIV_W-1:0]  ratio,
                                               input logic [TIME_W-1:0] t,
                                               input logic [TIME_W-1:0] start);
        logic [TIME_W-1:0] diff;
        int                sdiff;
        diff  = t - start;
        sdiff = int'(t) - int'(start);
        unique case (ratio)
            DIV_BY_1: align_extra = 2'h0;
            DIV_BY_2: align_extra = {1'b0, diff[0]};
            DIV_BY_3: align_extra = 2'(((sdiff % 3) + 3) % 3);
            DIV_BY_4: align_extra = diff[1:0];
        endcase
    endfunction

    antg_state_t         state_r, state_nxt;
    antg_req_t           req_r, cur_req;
    antg_cfg_t           cfg_r;
    logic [CNT_W-1:0]    cnt_r, step_acc_r;
    logic [BEAT_W:0]     beat_r, beat_nxt;
    logic [SYNC_LAT-1:0] hit_pipe_r;
    logic [DATA_W-1:0]   ad_meta_r, ad_sync_r, rdata_r, pin_wdata_r;
    logic                rdata_valid_r, ready_r, bus_turn_r;
    logic [ADDR_W-1:0]   pin_addr_r;
    logic [BE_W-1:0]     pin_be_r;
    logic [BEAT_W-1:0]   idx_nxt, nm1;
    logic                active, dbl, wr, beats_done, hit, access_done, clk_run;
    logic [CNT_W-1:0]    cs_at_w, cs_rel_w, adv_at_w, adv_rel_w, oe_at_w, oe_rel_w, we_at_w, we_rel_w;
    logic [CNT_W-1:0]    cyc_end_w, gap_w, step_w, samp_w, clk_start_w;
    assign active = (state_r == ST_ACCESS);
    assign dbl    = cfg_r.timing_scale_double;
    assign wr     = req_r.write;
    assign nm1    = req_r.beats_minus_1;

    // R13: select placed after address phase start
    // R10: select window stretched by page steps
    assign cs_at_w  = scale(CNT_W'(cfg_r.select_assert_time), dbl);
    assign cs_rel_w = scale(with_burst(wr ? cfg_r.select_write_release_time : cfg_r.select_read_release_time,
                                       nm1, cfg_r.page_step_time), dbl);
    // R14: address-valid placement
    // R4: read or write release field chosen
    assign adv_at_w  = scale(CNT_W'(cfg_r.addr_valid_assert_time), dbl);
    assign adv_rel_w = scale(CNT_W'(wr ? cfg_r.addr_valid_write_release_time
                                       : cfg_r.addr_valid_read_release_time), dbl);
    // R15: read strobe assert placement
    // R17: burst read strobe release adds page steps
    assign oe_at_w  = scale(CNT_W'(cfg_r.read_strobe_assert_time), dbl);
    assign oe_rel_w = wr ? '0 : scale(with_burst(cfg_r.read_strobe_release_time, nm1, cfg_r.page_step_time), dbl);
    // R19: write strobe assert placement
    assign we_at_w = wr ? scale(CNT_W'(cfg_r.write_strobe_assert_time), dbl) : '0;
    // R1: ratio 0 adds nothing, ratio 1 parity alignment
    // R2: ratio 2 mod-3 alignment
    // R3: ratio 3 mod-4 alignment
    assign we_rel_w = wr ? scale(CNT_W'(cfg_r.write_strobe_release_time), dbl)
                           + CNT_W'(align_extra(cfg_r.clk_divide_ratio, cfg_r.write_strobe_release_time,
                                                cfg_r.bus_clock_start_time))
                         : '0;
    // R9: cycle length stretched by page steps
    assign cyc_end_w = scale(with_burst(wr ? cfg_r.write_cycle_length : cfg_r.read_cycle_length,
                                        nm1, cfg_r.page_step_time), dbl);
    assign gap_w       = scale(CNT_W'(cfg_r.inter_access_gap), dbl);
    assign step_w      = scale(CNT_W'(cfg_r.page_step_time), dbl);
    assign clk_start_w = scale(CNT_W'(cfg_r.bus_clock_start_time), dbl);

    // R6: first word at the sample time
    // R7: first page word likewise
    // R8: each later word one page step on
    assign samp_w     = scale(CNT_W'(cfg_r.data_sample_time), dbl) + step_acc_r;
    assign beats_done = (beat_r > {1'b0, nm1});
    assign hit        = active && !beats_done && (cnt_r == samp_w);

    // Stretch past the cycle length if sampling is programmed late
    assign access_done = active && ((cnt_r + CNT_ONE) >= cyc_end_w) && beats_done && !hit
                         && (hit_pipe_r == '0);

    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            ST_IDLE: begin
                if (start_in && ready_r) begin
                    state_nxt = ST_ACCESS;
                end
            end
            ST_ACCESS: begin
                if (access_done) begin
                    state_nxt = (gap_w == '0) ? ST_IDLE : ST_GAP;
                end
            end
            ST_GAP: begin
                // R16: address held invalid through the gap
                if ((cnt_r + CNT_ONE) >= gap_w) begin
                    state_nxt = ST_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state_r <= ST_IDLE;
            ready_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            ready_r <= (state_nxt == ST_IDLE);
        end
    end

    // R23: counter restarts with each access
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            cnt_r <= '0;
        end else if (state_nxt != state_r || state_nxt == ST_IDLE) begin
            cnt_r <= '0;
        end else begin
            cnt_r <= cnt_r + CNT_ONE;
        end
    end

    // Timing latched per access so mid-access writes cannot glitch strobes
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            req_r <= '0;
            cfg_r <= '0;
        end else if (state_r == ST_IDLE && start_in) begin
            req_r <= req_in;
            cfg_r <= cfg_in;
        end
    end

    assign beat_nxt = (state_nxt != ST_ACCESS) ? '0 : (hit ? beat_r + (BEAT_W + 1)'(1) : beat_r);
    assign idx_nxt  = (beat_nxt > {1'b0, cur_req.beats_minus_1}) ? cur_req.beats_minus_1 : beat_nxt[BEAT_W-1:0];
    assign cur_req  = (state_r == ST_IDLE) ? req_in : req_r;

    // R18: next address follows each sample point
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            beat_r     <= '0;
            step_acc_r <= '0;
        end else begin
            beat_r     <= beat_nxt;
            step_acc_r <= (state_nxt != ST_ACCESS) ? '0 : (hit ? step_acc_r + step_w : step_acc_r);
        end
    end

    // R13: address, enables and data valid from cycle start
    // R16: address and enables parked outside the access
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            pin_addr_r  <= '0;
            pin_be_r    <= BE_NONE;
            pin_wdata_r <= '0;
        end else if (state_nxt == ST_ACCESS) begin
            pin_addr_r  <= cur_req.addr + ADDR_W'(idx_nxt);
            pin_be_r    <= cur_req.be_n;
            pin_wdata_r <= cur_req.wdata[idx_nxt];
        end else begin
            pin_addr_r  <= '0;
            pin_be_r    <= BE_NONE;
            pin_wdata_r <= '0;
        end
    end

    // R22: direction of shared bus, also driven out as ad_oe_out
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            bus_turn_r <= 1'b0;
        end else begin
            bus_turn_r <= (state_nxt == ST_ACCESS) && cur_req.write;
        end
    end

    // Pins launch on the falling edge, matching the strobe half-cycle grid
    always_ff @(negedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            addr_out  <= '0;
            be_n_out  <= BE_NONE;
            ad_out    <= '0;
            ad_oe_out <= 1'b0;
        end else begin
            addr_out  <= pin_addr_r;
            be_n_out  <= pin_be_r;
            ad_out    <= pin_wdata_r;
            ad_oe_out <= bus_turn_r;
        end
    end

    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            ad_meta_r <= '0;
            ad_sync_r <= '0;
        end else begin
            ad_meta_r <= ad_in;
            ad_sync_r <= ad_meta_r;
        end
    end

    // R24: synchroniser delay relies on data held to strobe release
    // R6: capture aligned to the sample point
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            hit_pipe_r    <= '0;
            rdata_r       <= '0;
            rdata_valid_r <= 1'b0;
        end else begin
            hit_pipe_r    <= {hit_pipe_r[SYNC_LAT-2:0], hit && !wr};
            rdata_valid_r <= hit_pipe_r[SYNC_LAT-1];
            if (hit_pipe_r[SYNC_LAT-1]) begin
                rdata_r <= ad_sync_r;
            end
        end
    end

    assign ready_out       = ready_r;
    assign rdata_out       = rdata_r;
    assign rdata_valid_out = rdata_valid_r;

    // R10: select strobe with its half-cycle option
    antg_strobe u_cs (
        .mclk_in (mclk_in), .rst_n_in (rst_n_in), .active_in (active), .cnt_in (cnt_r),
        .assert_at_in (cs_at_w), .release_at_in (cs_rel_w),
        .half_in (cfg_r.select_half_cycle_delay), .strobe_n_out (cs_n_out)
    );
    // R11: address-valid release with its own half-cycle option
    antg_strobe u_adv (
        .mclk_in (mclk_in), .rst_n_in (rst_n_in), .active_in (active), .cnt_in (cnt_r),
        .assert_at_in (adv_at_w), .release_at_in (adv_rel_w),
        .half_in (cfg_r.addr_valid_half_cycle_delay), .strobe_n_out (adv_n_out)
    );
    // R12: read strobe release with its half-cycle option
    antg_strobe u_oe (
        .mclk_in (mclk_in), .rst_n_in (rst_n_in), .active_in (active), .cnt_in (cnt_r),
        .assert_at_in (oe_at_w), .release_at_in (oe_rel_w),
        .half_in (cfg_r.read_strobe_half_cycle_delay), .strobe_n_out (oe_n_out)
    );
    // R20: write strobe release with its half-cycle option
    antg_strobe u_we (
        .mclk_in (mclk_in), .rst_n_in (rst_n_in), .active_in (active), .cnt_in (cnt_r),
        .assert_at_in (we_at_w), .release_at_in (we_rel_w),
        .half_in (cfg_r.write_strobe_half_cycle_delay), .strobe_n_out (we_n_out)
    );
    assign clk_run = active && (cnt_r >= clk_start_w);
    antg_bus_clock u_bus_clk (
        .mclk_in (mclk_in), .rst_n_in (rst_n_in), .run_in (clk_run),
        .ratio_in (cfg_r.clk_divide_ratio), .bus_clk_out (bus_clk_out)
    );

    AST_CS_ON: assert property (@(posedge mclk_in) disable iff (!rst_n_in) // R13
        (active && cnt_r == cs_at_w && cs_at_w < cs_rel_w && !cfg_r.select_half_cycle_delay)
        |-> !cs_n_out && (be_n_out == req_r.be_n)) else $error("select not low at assert time");
    AST_CS_REL: assert property (@(posedge mclk_in) disable iff (!rst_n_in) // R10
        (active && cnt_r == cs_rel_w && cs_at_w < cs_rel_w && cfg_r.select_half_cycle_delay)
        |=> cs_n_out) else $error("select not released at release time");
    AST_ADV_ON: assert property (@(posedge mclk_in) disable iff (!rst_n_in) // R14
        (active && cnt_r == adv_at_w && adv_at_w < adv_rel_w && !cfg_r.addr_valid_half_cycle_delay)
        |-> !adv_n_out) else $error("address valid not asserted on time");
    AST_ADV_REL: assert property (@(posedge mclk_in) disable iff (!rst_n_in) // R4
        (active && cnt_r == adv_rel_w - CNT_ONE && adv_at_w < adv_rel_w && !cfg_r.addr_valid_half_cycle_delay)
        |-> !adv_n_out ##1 adv_n_out) else $error("address valid width wrong");
    AST_OE_ON: assert property (@(posedge mclk_in) disable iff (!rst_n_in) // R15
        (active && !wr && cnt_r == oe_at_w && oe_at_w < oe_rel_w && cfg_r.read_strobe_half_cycle_delay)
        |=> !oe_n_out) else $error("read strobe not asserted on time");
    AST_OE_REL: assert property (@(posedge mclk_in) disable iff (!rst_n_in) // R17
        (active && !wr && cnt_r == oe_rel_w && oe_at_w < oe_rel_w && !cfg_r.read_strobe_half_cycle_delay)
        |-> oe_n_out) else $error("read strobe not released on time");
    AST_WE_ON: assert property (@(posedge mclk_in) disable iff (!rst_n_in) // R19
        (active && wr && cnt_r == we_at_w && we_at_w < we_rel_w && !cfg_r.write_strobe_half_cycle_delay)
        |-> !we_n_out && ad_oe_out) else $error("write strobe not asserted on time");
    AST_WE_REL: assert property (@(posedge mclk_in) disable iff (!rst_n_in) // R20
        (active && wr && cnt_r == we_rel_w - CNT_ONE && we_at_w < we_rel_w && !cfg_r.write_strobe_half_cycle_delay)
        |-> !we_n_out ##1 we_n_out) else $error("write strobe release misplaced");
    AST_SAMPLE: assert property (@(posedge mclk_in) disable iff (!rst_n_in) // R8
        (hit && !wr) |-> ##3 rdata_valid_out) else $error("read data not captured at sample point");
    AST_GAP: assert property (@(posedge mclk_in) disable iff (!rst_n_in) // R16
        (state_r == ST_GAP) |-> (be_n_out == BE_NONE) && (addr_out == '0)) else $error("address valid in gap");
    AST_BE_HOLD: assert property (@(posedge mclk_in) disable iff (!rst_n_in) // R9
        (active && cnt_r < cyc_end_w) |-> (be_n_out == req_r.be_n)) else $error("byte enables dropped early");

endmodule // antg_timing_gen

// file: dv/antg_nor_model.sv
module antg_nor_model
    import antg_pkg::*;
(
    input  wire logic              mclk_in,
    input  wire logic              cs_n_in,
    input  wire logic              oe_n_in,
    input  wire logic              we_n_in,
    input  wire logic [ADDR_W-1:0] addr_in,
    input  wire logic [DATA_W-1:0] ad_in,
    input  wire logic              ad_oe_in,
    output logic      [DATA_W-1:0] ad_out,
    output logic      [DATA_W-1:0] wr_data_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [DATA_W-1:0] last_r = 16'h0000;
    logic              we_d_r = 1'b1;
    always_comb begin
        if (!cs_n_in && !oe_n_in)
            ad_out = addr_in[DATA_W-1:0] ^ 16'h3C3C;
        else
            ad_out = ~last_r;
    end
    always_ff @(posedge mclk_in) begin
        last_r <= ad_out;
        we_d_r <= we_n_in;
        if (we_n_in && !we_d_r && !cs_n_in && ad_oe_in)
            wr_data_out <= ad_in;
    end
endmodule // antg_nor_model

// file: dv/tb_antg_timing_gen.sv
module tb_antg_timing_gen
    import antg_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk_in = 1'b0, rst_n_in = 1'b0, start_in = 1'b0;
    antg_req_t req = '0, r;
    antg_cfg_t cfg = '0, c;
    logic [DATA_W-1:0] ad_in, ad_out, rdata, wr_data;
    logic ready, cs_n, adv_n, oe_n, we_n, bclk, ad_oe, rvalid;
    logic [ADDR_W-1:0] addr;
    logic [BE_W-1:0] be_n;
    int n_fail = 0, check_count = 0, k, nv, gapc, becnt, s, p, m, bp, br, per, t[8];
    always #20 mclk_in = ~mclk_in;
    antg_timing_gen dut(.mclk_in(mclk_in), .rst_n_in(rst_n_in), .start_in(start_in), .req_in(req),
        .cfg_in(cfg), .ad_in(ad_in), .ready_out(ready), .cs_n_out(cs_n), .adv_n_out(adv_n),
        .oe_n_out(oe_n), .we_n_out(we_n), .bus_clk_out(bclk), .addr_out(addr), .be_n_out(be_n),
        .ad_out(ad_out), .ad_oe_out(ad_oe), .rdata_out(rdata), .rdata_valid_out(rvalid));
    antg_nor_model mem(.mclk_in(mclk_in), .cs_n_in(cs_n), .oe_n_in(oe_n), .we_n_in(we_n),
        .addr_in(addr), .ad_in(ad_out), .ad_oe_in(ad_oe), .ad_out(ad_in), .wr_data_out(wr_data));
    task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD %s exp %0h got %0h", nm, exp, got);
        end
    endtask
    task automatic results();
        $display("checks %0d fails %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic mark(input logic v, input int i);
        if (v === 1'b0 && t[i] == 0) t[i] = k;
        if (v === 1'b1 && t[i] != 0 && t[i+1] == 0) t[i+1] = k;
    endtask
    // One access, then edge-indexed strobe checks
    task automatic run(input string nm);
        @(posedge mclk_in);
        cfg <= c;
        req <= r;
        start_in <= 1'b1;
        @(posedge mclk_in);
        start_in <= 1'b0;
        t = '{default:0};
        k = 0; nv = 0; gapc = 0; becnt = 0; bp = 0; br = 0; per = 0;
        while (k < 500 && !(k > 2 && ready === 1'b1)) begin
            @(posedge mclk_in);
            k++;
            mark(cs_n, 0); mark(adv_n, 2); mark(oe_n, 4); mark(we_n, 6);
            // Bus clock period between rising edges
            if (bclk === 1'b1 && bp == 0 && br != 0) per = k - br;
            if (bclk === 1'b1 && bp == 0) br = k;
            bp = (bclk === 1'b1);
            if (rvalid === 1'b1) begin
                chk("rdata", rdata, 16'(r.addr + ADDR_W'(nv)) ^ 16'h3C3C);
                nv++;
            end
            if (be_n !== BE_NONE) becnt++;
            else if (t[1] != 0) gapc++;
        end
        if (k >= 500) n_fail++;
        s = c.timing_scale_double ? 2 : 1;
        p = r.beats_minus_1 * c.page_step_time;
        chk("cs_on", t[0], c.select_assert_time * s + 1 + c.select_half_cycle_delay);
        chk("adv_on", t[2], c.addr_valid_assert_time * s + 1 + c.addr_valid_half_cycle_delay);
        chk("gap", gapc >= c.inter_access_gap * s, 1);
        if (r.write) begin
            m = c.clk_divide_ratio + 1;
            m = ((c.write_strobe_release_time - c.bus_clock_start_time) % m + m) % m;
            chk("cs_off", t[1], (c.select_write_release_time + p) * s + 1 + c.select_half_cycle_delay);
            chk("adv_off", t[3], c.addr_valid_write_release_time * s + 1 + c.addr_valid_half_cycle_delay);
            chk("we_on", t[6], c.write_strobe_assert_time * s + 1 + c.write_strobe_half_cycle_delay);
            chk("we_off", t[7], c.write_strobe_release_time * s + 1 + m + c.write_strobe_half_cycle_delay);
            chk("bclk_per", per, c.clk_divide_ratio == 0 ? 0 : c.clk_divide_ratio + 1);
            chk("be", becnt, (c.write_cycle_length + p) * s);
            if (r.beats_minus_1 == 0) chk("wdata", wr_data, r.wdata[0]);
        end else begin
            chk("cs_off", t[1], (c.select_read_release_time + p) * s + 1 + c.select_half_cycle_delay);
            chk("adv_off", t[3], c.addr_valid_read_release_time * s + 1 + c.addr_valid_half_cycle_delay);
            chk("oe_on", t[4], c.read_strobe_assert_time * s + 1 + c.read_strobe_half_cycle_delay);
            chk("oe_off", t[5], (c.read_strobe_release_time + p) * s + 1 + c.read_strobe_half_cycle_delay);
            chk("words", nv, r.beats_minus_1 + 1);
            chk("be", becnt, (c.read_cycle_length + p) * s);
        end
        $display("test %s done", nm);
    endtask
    initial begin
        #200000;
        n_fail++;
        results();
    end
    initial begin
        repeat (3) @(posedge mclk_in);
        rst_n_in <= 1'b1;
        repeat (2) @(posedge mclk_in);
        c = '0;
        c.addr_valid_read_release_time = 5'h02;
        c.read_strobe_assert_time = 5'h01;
        c.read_strobe_release_time = 5'h05;
        c.data_sample_time = 5'h04;
        c.select_read_release_time = 5'h06;
        c.read_cycle_length = 5'h08;
        c.inter_access_gap = 5'h02;
        c.page_step_time = 5'h04;
        r = '0;
        r.addr = 24'h012340;
        r.be_n = 2'h0;
        run("single_read");
        r.beats_minus_1 = 2'h3;
        c.timing_scale_double = 1'b1;
        c.addr_valid_half_cycle_delay = 1'b1;
        c.read_strobe_half_cycle_delay = 1'b1;
        run("burst_read");
        c = '0;
        c.select_assert_time = 5'h01;
        c.addr_valid_assert_time = 5'h01;
        c.addr_valid_write_release_time = 5'h03;
        c.write_strobe_assert_time = 5'h02;
        c.write_strobe_release_time = 5'h06;
        c.select_write_release_time = 5'h0B;
        c.write_cycle_length = 5'h0C;
        c.bus_clock_start_time = 5'h01;
        c.inter_access_gap = 5'h03;
        // Bursts need a nonzero page step to advance beats
        c.page_step_time = 5'h02;
        r.write = 1'b1;
        r.wdata = 64'hA5A5_1234_5678_9ABC;
        for (int i = 0; i < 4; i++) begin
            c.clk_divide_ratio = DIV_W'(i);
            c.write_strobe_half_cycle_delay = i[0];
            c.select_half_cycle_delay = i[1];
            r.beats_minus_1 = BEAT_W'(i);
            run("write");
        end
        results();
    end
endmodule // tb_antg_timing_gen
